// ### include/fault_pkg.sv
package fault_pkg;

	// ----------------------------------------
	// Exception vectors
	// ----------------------------------------
	localparam logic [7:0] VEC_TS = 8'h0a;
	localparam logic [7:0] VEC_SS = 8'h0c;
	localparam logic [7:0] VEC_GP = 8'h0d;

	// ----------------------------------------
	// Limits and widths
	// ----------------------------------------
	localparam int MAX_INSN_LEN = 15;
	localparam int DESC_BYTES = 8;
	localparam int ALIGN_W = 4;
	localparam int MIN_LEN_W = 5;

	// ----------------------------------------
	// Segment register and control register selects
	// ----------------------------------------
	localparam logic [2:0] SEG_ES = 3'h0;
	localparam logic [2:0] SEG_CS = 3'h1;
	localparam logic [2:0] SEG_SS = 3'h2;
	localparam logic [2:0] CRN_0 = 3'h0;
	localparam logic [2:0] CRN_3 = 3'h3;
	localparam logic [2:0] CRN_4 = 3'h4;

	// ----------------------------------------
	// Descriptor attribute bits and system types
	// ----------------------------------------
	localparam int ATTR_P = 0;
	localparam int ATTR_S = 1;
	localparam int ATTR_X = 2;
	localparam int ATTR_RW = 3;
	localparam logic [3:0] SYS_LDT = 4'h2;
	localparam logic [3:0] SYS_TASKG = 4'h5;
	localparam logic [3:0] SYS_TSS_AVL = 4'h9;
	localparam logic [3:0] SYS_TSS_BUSY = 4'hb;
	localparam logic [3:0] SYS_INTG = 4'he;
	localparam logic [3:0] SYS_TRAPG = 4'hf;

	// ----------------------------------------
	// Control register zero bits and error code bits
	// ----------------------------------------
	localparam int CR0_PE = 0;
	localparam int CR0_NW = 29;
	localparam int CR0_CD = 30;
	localparam int CR0_PG = 31;
	localparam int EC_TI = 2;

	// ----------------------------------------
	// Register port map
	// ----------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam logic [7:0] REG_EIP = 8'h08;
	localparam logic [7:0] REG_CS = 8'h0c;
	localparam int CTRL_EN = 0;
	localparam logic CTRL_EN_RST = 1'b1;

	// ----------------------------------------
	// Check operations
	// ----------------------------------------
	typedef enum logic [3:0] {
		OP_MEM = 4'h0,
		OP_ENTER = 4'h1,
		OP_SEGLD = 4'h2,
		OP_XFER = 4'h3,
		OP_GATE = 4'h4,
		OP_INT = 4'h5,
		OP_TASK = 4'h6,
		OP_LOAD_LOCAL_TABLE_INSTR = 4'h7,
		OP_LTR = 4'h8,
		OP_CRW = 4'h9,
		OP_MSRW = 4'ha,
		OP_VCSRW = 4'hb,
		OP_PRIV = 4'hc,
		OP_DECODE = 4'hd
	} op_e;

endpackage

// ### design/seg_limit_check.sv
`timescale 1ns/1ns
`default_nettype none

// Flags an access whose last byte lies beyond the limit. A zero length
// never faults, so an idle request cannot raise a spurious violation.
module seg_limit_check #(
	parameter int LEN_W = 5
) (
	// access
	input wire logic [31:0] off,
	input wire logic [LEN_W-1:0] len,
	input wire logic [31:0] limit,
	// result
	output logic viol
);

	logic [32:0] lastByte;

	generate
		if (LEN_W < fault_pkg::MIN_LEN_W || LEN_W > 32) begin : gBadLen
			$error("length width out of range");
		end
	endgenerate

	assign lastByte = {1'b0, off} + 33'(len) - 33'h1;
	assign viol = (len != '0) && (lastByte > {1'b0, limit});

endmodule // seg_limit_check

`default_nettype wire

// ### design/stack_and_protection_fault_detect.sv
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none

// Contract
// - Any stack segment access beyond its limit raises stack fault, vector 12; a misaligned vector access here raises protection fault instead.
// - Frame entry lacking stack space for locals raises stack fault.
// - Loading the stack segment register with a not-present segment: stack fault.
// - Stack fault code: selector for not-present or new-stack overflow, else zero.
// - Saved pointer names faulting instruction; new task's first after commit.
// - Task switch faults wait until remaining state loaded without further checks; here only faults past the commit point wait.
// - Outside task switches the faulting instruction is squashed, restartable.
// - Protection fault only where no other listed exception applies.
// - Code or data segment limit, or table limit overrun: protection fault.
// - Jump to non-code, write to code or read-only, read execute-only faults.
// - Segment register loads with wrong selector kinds fault; null data use faults.
// - Busy task call, non-busy task return, local task descriptor fault.
// - Instruction longer than fifteen bytes raises protection fault.
// - Control zero write with paging without protection, or bad cache combo.
// - Reserved bits set in control four, model register or vector status fault.
// - Privileged instruction with privilege level not zero faults.
// - Bad interrupt table entry, soft interrupt privilege, or v86 handler level.
// - Null gate selector, gate not to code, or null target code selector.
// - Bad local table load or task register load selectors fault.
// - Page pointer entries with reserved bits set fault on reload writes.
// - Misaligned 128-bit vector operands fault, stack segment included.
// - Protection code holds selector or vector when loading descriptors, else zero.
// - Selector code carries external event flag and interrupt table flag.
module stack_and_protection_fault_detect #(
	parameter logic [31:0] CR4_RSV = 32'hfffff800,
	parameter logic [31:0] VCSR_RSV = 32'hffff0000,
	parameter int LEN_W = 5
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	// check request
	input wire logic reqValid,
	output logic reqReady,
	input wire fault_pkg::op_e reqOp,
	input wire logic [2:0] reqSeg,
	input wire logic [31:0] reqOff,
	input wire logic [LEN_W-1:0] reqLen,
	input wire logic [31:0] reqLimit,
	input wire logic reqWrite,
	input wire logic reqAlign,
	input wire logic [15:0] reqSel,
	input wire logic [3:0] reqAttr,
	input wire logic [3:0] reqType,
	input wire logic [1:0] reqDpl,
	input wire logic [1:0] tgtDpl,
	input wire logic [7:0] reqVec,
	input wire logic [31:0] reqData,
	input wire logic [31:0] reqMask,
	// processor context
	input wire logic [1:0] current_priv_level,
	input wire logic v86,
	input wire logic softInt,
	input wire logic extEvent,
	input wire logic iretSw,
	input wire logic taskSw,
	input wire logic pastCommit,
	input wire logic stackSw,
	input wire logic newStack,
	input wire logic paeOn,
	input wire logic pseOn,
	input wire logic pdpteRsv,
	input wire logic loadDone,
	input wire logic [15:0] faultCs,
	input wire logic [31:0] faultEip,
	input wire logic [15:0] newCs,
	input wire logic [31:0] newEip,
	// exception report
	output logic excValid,
	output logic [7:0] excVector,
	output logic [15:0] excCode,
	output logic [15:0] excCs,
	output logic [31:0] excEip,
	output logic squash,
	output logic skipChecks
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b11,
		ST_REPORT = 2'b01
	} state_e;

	typedef struct packed {
		state_e st;
		logic excValid;
		logic [7:0] vec;
		logic [15:0] code;
		logic [15:0] cs;
		logic [31:0] instr_pointer;
		logic squash;
		logic enable;
		logic [7:0] count;
		logic [31:0] rdata;
	} state_s;

	localparam state_s RST_S = '{
		st: ST_IDLE, excValid: 1'b0, vec: 8'h00, code: 16'h0000,
		cs: 16'h0000, instr_pointer: 32'h0, squash: 1'b0,
		enable: fault_pkg::CTRL_EN_RST, count: 8'h00, rdata: 32'h0
	};

	state_s r_q;
	state_s r_d;
	logic memViol;
	logic tblViol;
	logic fault;
	logic [7:0] vecC;
	logic [15:0] codeC;
	logic [15:0] selEc;
	logic [15:0] idtEc;
	logic isNull;
	logic isSys;
	logic isCode;
	logic isRw;
	logic isPres;
	logic isGate;
	logic dataSeg;
	logic go;
	logic useNew;

	// ----------------------------------------
	// Limit checks
	// ----------------------------------------
	seg_limit_check #(.LEN_W(LEN_W)) memChk (
		.off(reqOff),
		.len(reqLen),
		.limit(reqLimit),
		.viol(memViol)
	);

	seg_limit_check #(.LEN_W(LEN_W)) tblChk (
		.off({16'h0000, reqSel[15:3], 3'h0}),
		.len(LEN_W'(fault_pkg::DESC_BYTES)),
		.limit(reqLimit),
		.viol(tblViol)
	);

	// ----------------------------------------
	// Operand decode
	// ----------------------------------------
	assign isNull = reqSel[15:2] == 14'h0000;
	assign isSys = !reqAttr[fault_pkg::ATTR_S];
	assign isCode = reqAttr[fault_pkg::ATTR_X] && !isSys;
	assign isRw = reqAttr[fault_pkg::ATTR_RW];
	assign isPres = reqAttr[fault_pkg::ATTR_P];
	assign isGate = isSys && (reqType == fault_pkg::SYS_INTG
		|| reqType == fault_pkg::SYS_TRAPG
		|| reqType == fault_pkg::SYS_TASKG);
	assign dataSeg = reqSeg != fault_pkg::SEG_CS
		&& reqSeg != fault_pkg::SEG_SS;
	// Index, table bit, interrupt table flag, external flag.
	assign selEc = {reqSel[15:3], reqSel[fault_pkg::EC_TI], 1'b0,
		extEvent};
	assign idtEc = {5'h00, reqVec, 1'b0, 1'b1, extEvent};
	assign useNew = taskSw && pastCommit;
	assign go = reqValid && reqReady && r_q.enable;

	// ----------------------------------------
	// Fault classification
	// ----------------------------------------
	// Not-present cases other than the stack one belong to other units; invalid
	// task state is raised here only for a non-writable stack load in a task switch.
	always_comb begin
		fault = 1'b0;
		vecC = fault_pkg::VEC_GP;
		codeC = 16'h0000;
		case (reqOp)
		fault_pkg::OP_MEM: begin
			if (reqAlign && |reqOff[fault_pkg::ALIGN_W-1:0]) begin
				fault = 1'b1;
			end else if (reqSeg == fault_pkg::SEG_SS && memViol) begin
				fault = 1'b1;
				vecC = fault_pkg::VEC_SS;
				codeC = newStack ? selEc : 16'h0000;
			end else if (memViol) begin
				fault = 1'b1;
			end else if (dataSeg && isNull) begin
				fault = 1'b1;
			end else if (reqWrite ? (isCode || !isRw)
				: (isCode && !isRw)) begin
				fault = 1'b1;
			end
		end
		fault_pkg::OP_ENTER: begin
			if (memViol) begin
				fault = 1'b1;
				vecC = fault_pkg::VEC_SS;
			end
		end
		fault_pkg::OP_SEGLD: begin
			codeC = selEc;
			if (tblViol && !(taskSw || stackSw)) begin
				fault = 1'b1;
			end else if (reqSeg == fault_pkg::SEG_SS) begin
				if (isNull || isSys || isCode) begin
					fault = 1'b1;
				end else if (!isRw) begin
					fault = 1'b1;
					vecC = taskSw ? fault_pkg::VEC_TS : fault_pkg::VEC_GP;
				end else if (!isPres) begin
					fault = 1'b1;
					vecC = fault_pkg::VEC_SS;
				end
			end else if (reqSeg == fault_pkg::SEG_CS) begin
				fault = isNull || isSys || !isCode;
			end else begin
				fault = !isNull && (isSys || (isCode && !isRw));
			end
		end
		fault_pkg::OP_XFER: begin
			codeC = selEc;
			if (isNull) begin
				fault = 1'b1;
			end else if (tblViol && !taskSw) begin
				fault = 1'b1;
			end else if (isSys || !isCode) begin
				fault = 1'b1;
			end
		end
		fault_pkg::OP_GATE: begin
			codeC = selEc;
			fault = isNull || isSys || !isCode;
		end
		fault_pkg::OP_INT: begin
			codeC = idtEc;
			if (!isGate) begin
				fault = 1'b1;
			end else if (softInt && current_priv_level > reqDpl) begin
				fault = 1'b1;
			end else if (v86 && reqType != fault_pkg::SYS_TASKG
				&& tgtDpl != 2'h0) begin
				fault = 1'b1;
				codeC = selEc;
			end
		end
		fault_pkg::OP_TASK: begin
			codeC = selEc;
			if (reqSel[fault_pkg::EC_TI]) begin
				fault = 1'b1;
			end else if (iretSw) begin
				fault = reqType == fault_pkg::SYS_TSS_AVL;
			end else begin
				fault = reqType == fault_pkg::SYS_TSS_BUSY;
			end
		end
		fault_pkg::OP_LOAD_LOCAL_TABLE_INSTR: begin
			codeC = selEc;
			fault = reqSel[fault_pkg::EC_TI] || (!isNull && (tblViol
				|| !isSys || reqType != fault_pkg::SYS_LDT));
		end
		fault_pkg::OP_LTR: begin
			codeC = selEc;
			fault = reqSel[fault_pkg::EC_TI] || tblViol || !isSys
				|| reqType != fault_pkg::SYS_TSS_AVL;
		end
		fault_pkg::OP_CRW: begin
			if (reqSeg == fault_pkg::CRN_0
				&& ((reqData[fault_pkg::CR0_PG] && !reqData[fault_pkg::CR0_PE])
				|| (reqData[fault_pkg::CR0_NW]
				&& !reqData[fault_pkg::CR0_CD]))) begin
				fault = 1'b1;
			end else if (reqSeg == fault_pkg::CRN_4
				&& |(reqData & CR4_RSV)) begin
				fault = 1'b1;
			end else if ((paeOn || pseOn) && pdpteRsv
				&& (reqSeg == fault_pkg::CRN_0 || reqSeg == fault_pkg::CRN_3
				|| reqSeg == fault_pkg::CRN_4)) begin
				fault = 1'b1;
			end
		end
		fault_pkg::OP_MSRW: begin
			fault = |(reqData & reqMask);
		end
		fault_pkg::OP_VCSRW: begin
			fault = |(reqData & VCSR_RSV);
		end
		fault_pkg::OP_PRIV: begin
			fault = current_priv_level != 2'h0;
		end
		fault_pkg::OP_DECODE: begin
			fault = reqLen > LEN_W'(fault_pkg::MAX_INSN_LEN);
		end
		default: begin
			fault = 1'b0;
		end
		endcase
	end

	// ----------------------------------------
	// Sequencing and registers
	// ----------------------------------------
	// A fault past the task switch commit point parks in the wait state, so
	// the loader finishes the new task's state before the handler runs.
	always_comb begin
		r_d = r_q;
		r_d.excValid = 1'b0;
		r_d.rdata = 32'h0;
		if (regWr && regAddr == fault_pkg::REG_CTRL) begin
			r_d.enable = regWdata[fault_pkg::CTRL_EN];
		end
		if (regRd) begin
			case (regAddr)
			fault_pkg::REG_CTRL: r_d.rdata = {31'h0, r_q.enable};
			fault_pkg::REG_STAT: r_d.rdata = {r_q.code, r_q.count, r_q.vec};
			fault_pkg::REG_EIP: r_d.rdata = r_q.instr_pointer;
			fault_pkg::REG_CS: r_d.rdata = {16'h0000, r_q.cs};
			default: r_d.rdata = 32'h0;
			endcase
		end
		case (r_q.st)
		ST_IDLE: begin
			if (go && fault) begin
				r_d.vec = vecC;
				r_d.code = codeC;
				r_d.cs = useNew ? newCs : faultCs;
				r_d.instr_pointer = useNew ? newEip : faultEip;
				r_d.squash = !useNew;
				if (useNew) begin
					r_d.st = ST_WAIT;
				end else begin
					r_d.st = ST_REPORT;
					r_d.excValid = 1'b1;
					r_d.count = r_q.count + 8'h01;
				end
			end
		end
		ST_WAIT: begin
			if (loadDone) begin
				r_d.st = ST_REPORT;
				r_d.excValid = 1'b1;
				r_d.count = r_q.count + 8'h01;
			end
		end
		ST_REPORT: begin
			r_d.st = ST_IDLE;
		end
		default: begin
			r_d.st = ST_IDLE;
		end
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			r_q <= RST_S;
		end else if (ce) begin
			r_q <= r_d;
		end
	end

	assign regRdata = r_q.rdata;
	assign reqReady = r_q.st == ST_IDLE;
	assign skipChecks = r_q.st == ST_WAIT;
	assign excValid = r_q.excValid;
	assign excVector = r_q.vec;
	assign excCode = r_q.code;
	assign excCs = r_q.cs;
	assign excEip = r_q.instr_pointer;
	assign squash = r_q.squash;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	AST_SS_LIMIT: assert property (
		go && ce && reqOp == fault_pkg::OP_MEM && !useNew
		&& reqSeg == fault_pkg::SEG_SS && memViol && !reqAlign
		|=> excValid && excVector == fault_pkg::VEC_SS
	) else $error("stack limit overrun not reported as stack fault");

	AST_SS_ENTER: assert property (
		go && ce && reqOp == fault_pkg::OP_ENTER && memViol && !useNew
		|=> excValid && excVector == fault_pkg::VEC_SS && excCode == 16'h0
	) else $error("frame entry overrun not reported");

	AST_SS_CODE: assert property (
		go && ce && reqOp == fault_pkg::OP_MEM && newStack && !useNew
		&& reqSeg == fault_pkg::SEG_SS && memViol && !reqAlign
		|=> excCode[15:3] == $past(reqSel[15:3])
	) else $error("new stack overflow code lacks selector");

	AST_EIP: assert property (
		go && ce && fault && !useNew
		|=> excEip == $past(faultEip) && excCs == $past(faultCs)
	) else $error("saved pointer not the faulting instruction");

	AST_WAIT: assert property (
		skipChecks |-> !excValid
	) else $error("task switch fault not held for state load");

	AST_DONE: assert property (
		skipChecks && ce && loadDone |=> excValid
	) else $error("late fault not reported");

	AST_SQUASH: assert property (
		go && ce && fault && !useNew |=> excValid && squash
	) else $error("faulting instruction not squashed");

	AST_LEN: assert property (
		go && ce && reqOp == fault_pkg::OP_DECODE && !useNew
		|=> excValid == ($past(reqLen) > LEN_W'(fault_pkg::MAX_INSN_LEN))
	) else $error("instruction length check wrong");

	AST_CR0: assert property (
		go && ce && reqOp == fault_pkg::OP_CRW && !useNew
		&& reqSeg == fault_pkg::CRN_0 && reqData[fault_pkg::CR0_PG]
		&& !reqData[fault_pkg::CR0_PE]
		|=> excValid && excVector == fault_pkg::VEC_GP
	) else $error("paging without protection not refused");

	AST_PRIV: assert property (
		go && ce && reqOp == fault_pkg::OP_PRIV && current_priv_level != 2'h0 && !useNew
		|=> excValid && excVector == fault_pkg::VEC_GP && excCode == 16'h0
	) else $error("privileged instruction at user level not refused");

	AST_ONE: assert property (
		excValid && ce |=> !excValid
	) else $error("one fault reported more than once");

endmodule // stack_and_protection_fault_detect

`default_nettype wire

// ### tb/load_partner.sv
`timescale 1ns/1ns
`default_nettype none

// Stands in for the descriptor loader. While the block holds back a late
// task-switch fault it finishes loading the new task state after lag
// cycles and then pulses loadDone once; a lag of zero answers at once.
module load_partner (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// loader handshake
	input wire logic skipChecks,
	input wire logic [3:0] lag,
	output logic loadDone
);
	logic [3:0] cnt_q;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt_q <= 4'h0;
			loadDone <= 1'h0;
		end else begin
			loadDone <= 1'h0;
			cnt_q <= 4'h0;
			if (skipChecks && !loadDone) begin
				if (cnt_q == lag)
					loadDone <= 1'h1;
				else
					cnt_q <= cnt_q + 4'h1;
			end
		end
	end
endmodule // load_partner

`default_nettype wire

// ### tb/stack_and_protection_fault_detect_bench.sv
`timescale 1ns/1ns
`default_nettype none

module stack_and_protection_fault_detect_bench;
	// ----------------------------------------
	// Stimulus and design
	// ----------------------------------------
	logic clock = 1'h0, rst = 1'h1, regWr = 1'h0, regRd = 1'h0;
	logic [7:0] regAddr = 8'h00, reqVec = 8'h00, lastVec = 8'h00;
	logic [31:0] regWdata = 32'h0, reqOff = 32'h0, reqLimit = 32'h0;
	logic [31:0] reqData = 32'h0, reqMask = 32'h0, faultEip = 32'h0;
	logic [31:0] newEip = 32'h0, regRdata, excEip, lastIp = 32'h0;
	logic reqValid = 1'h0, reqWrite = 1'h0, reqAlign = 1'h0, reqReady;
	fault_pkg::op_e reqOp = fault_pkg::OP_MEM;
	logic [2:0] reqSeg = 3'h0;
	logic [4:0] reqLen = 5'h0;
	logic [15:0] reqSel = 16'h0, faultCs = 16'h0, newCs = 16'h0;
	logic [15:0] excCode, excCs, lastCs = 16'h0, lastCode = 16'h0;
	logic [3:0] reqAttr = 4'h0, reqType = 4'h0, lag = 4'h0;
	logic [1:0] reqDpl = 2'h0, tgtDpl = 2'h0, current_priv_level = 2'h0;
	logic v86 = 1'h0, softInt = 1'h0, extEvent = 1'h0, iretSw = 1'h0;
	logic taskSw = 1'h0, pastCommit = 1'h0, newStack = 1'h0;
	logic paeOn = 1'h0, pdpteRsv = 1'h0, loadDone;
	logic excValid, squash, skipChecks;
	logic [7:0] excVector;
	int errors = 0, checks_done = 0;

	stack_and_protection_fault_detect #(.LEN_W(5)) DUT (
		.clock, .rst, .ce(1'h1), .regAddr, .regWdata, .regWr, .regRd,
		.regRdata, .reqValid, .reqReady, .reqOp, .reqSeg, .reqOff, .reqLen,
		.reqLimit, .reqWrite, .reqAlign, .reqSel, .reqAttr, .reqType,
		.reqDpl, .tgtDpl, .reqVec, .reqData, .reqMask, .current_priv_level, .v86, .softInt,
		.extEvent, .iretSw, .taskSw, .pastCommit, .stackSw(1'h0), .newStack,
		.paeOn, .pseOn(1'h0), .pdpteRsv, .loadDone, .faultCs, .faultEip,
		.newCs, .newEip, .excValid, .excVector, .excCode, .excCs, .excEip,
		.squash, .skipChecks
	);
	load_partner partner (.clock, .rst, .skipChecks, .lag, .loadDone);

	initial begin
		forever #5 clock = ~clock;
	end

	// ----------------------------------------
	// Checking tasks
	// ----------------------------------------
	task automatic cmp(logic [31:0] got, logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("FAIL at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic results();
		$display("Checks made %0d, mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	function automatic logic [15:0] ic(logic [7:0] vec, logic external_event_flag);
		return {5'h00, vec, 2'h1, external_event_flag};
	endfunction

	function automatic logic [7:0] lv(logic [2:0] seg);
		return (seg == fault_pkg::SEG_SS) ? fault_pkg::VEC_SS : fault_pkg::VEC_GP;
	endfunction

	task automatic wreg(logic [7:0] a, logic [31:0] d);
		@(posedge clock);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'h1;
		@(posedge clock);
		regWr <= 1'h0;
	endtask

	task automatic rreg(logic [7:0] a, output logic [31:0] v);
		@(posedge clock);
		regAddr <= a;
		regRd <= 1'h1;
		@(posedge clock);
		regRd <= 1'h0;
		#1 v = regRdata;
		@(posedge clock);
		#1 cmp(regRdata, 32'h0);
	endtask

	// Flag bits, high first: softInt, extEvent, iretSw, v86, taskSw,
	// pastCommit, newStack, paeOn, pdpteRsv.
	task automatic ctx(logic [1:0] c, logic [8:0] f, logic [1:0] d,
		logic [1:0] t, logic [7:0] vec, logic [31:0] m);
		@(posedge clock);
		current_priv_level <= c;
		{softInt, extEvent, iretSw, v86, taskSw, pastCommit, newStack, paeOn,
			pdpteRsv} <= f;
		reqDpl <= d;
		tgtDpl <= t;
		reqVec <= vec;
		reqMask <= m;
	endtask

	// One request; ev of zero means no report may follow. The value that
	// register writes carry rides in of, as the offset is unused there.
	task automatic run(logic [3:0] op, logic [2:0] sg, logic [15:0] sl,
		logic [7:0] ta, logic [31:0] of, logic [31:0] lm, logic [4:0] ln,
		logic [1:0] wa, logic [7:0] ev, logic [15:0] ec);
		logic [15:0] cs;
		logic [31:0] ip;
		logic late;
		int n;
		cs = 16'($urandom);
		ip = $urandom;
		@(posedge clock);
		late = taskSw & pastCommit;
		reqOp <= fault_pkg::op_e'(op);
		reqSeg <= sg;
		reqSel <= sl;
		{reqType, reqAttr} <= ta;
		reqOff <= of;
		reqData <= of;
		reqLimit <= lm;
		reqLen <= ln;
		{reqWrite, reqAlign} <= wa;
		faultCs <= cs;
		faultEip <= ip;
		newCs <= ~cs;
		newEip <= ~ip;
		reqValid <= 1'h1;
		#1 cmp(reqReady, 1'h1);
		@(posedge clock);
		reqValid <= 1'h0;
		#1;
		if (ev == 8'h00) begin
			cmp(excValid, 1'h0);
			cmp(excVector, lastVec);
		end else begin
			if (late) begin
				cmp(skipChecks, 1'h1);
				cmp(excValid, 1'h0);
				for (n = 0; n < 40 && excValid !== 1'h1; n++) begin
					@(posedge clock);
					#1;
				end
				cs = ~cs;
				ip = ~ip;
			end
			cmp(excValid, 1'h1);
			cmp(excVector, ev);
			cmp(excCode, ec);
			cmp(excCs, cs);
			cmp(excEip, ip);
			cmp(squash, !late);
			cmp(skipChecks, 1'h0);
			cmp(reqReady, 1'h0);
			lastVec = ev;
			lastCode = ec;
			lastCs = cs;
			lastIp = ip;
		end
		@(posedge clock);
		#1 cmp(excValid, 1'h0);
	endtask

	task automatic ld(logic [3:0] op, logic [2:0] sg, logic [15:0] sl,
		logic [7:0] ta, logic [31:0] of, logic [7:0] ev, logic [15:0] ec);
		run(op, sg, sl, ta, of, 32'hffff, 5'h0, 2'h0, ev, ec);
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	// Operation codes: 0 memory, 1 frame entry, 2 segment load, 3 transfer,
	// 4 gate, 5 interrupt, 6 task, 7 local table, 8 task register,
	// 9 control write, a model register, b vector status, c privileged,
	// d decode.
	initial begin
		logic [31:0] v, lm;
		logic [2:0] s;
		logic [4:0] ln;
		logic x;
		int i;
		void'($urandom(32'h0ca2b3c8));
		repeat (2) @(posedge clock);
		rst <= 1'h0;
		rreg(fault_pkg::REG_CTRL, v);
		cmp(v[fault_pkg::CTRL_EN], fault_pkg::CTRL_EN_RST);
		cmp(excValid, 1'h0);
		wreg(8'h10, 32'hffffffff);
		rreg(8'h10, v);
		cmp(v, 32'h0);
		$display("Test reset and registers done");
		for (i = 0; i < 12; i++) begin
			s = (i % 3 == 0) ? 3'h2 : 3'(2 * (i % 3) - 1);
			x = 1'((i / 3) % 2);
			ln = 5'($urandom_range(16, 1));
			lm = $urandom_range(32'h0000ffff, 32'h20);
			run(4'h0, s, 16'h0008, (s == 3'h1) ? 8'h0f : 8'h0b, lm - ln + 1 + x,
				lm, ln, 2'h0, x ? lv(s) : 8'h00, 16'h0);
		end
		$display("Test limit boundaries done");
		run(4'h1, 3'h2, 16'h10, 8'h0b, 32'h0ff1, 32'h0fff, 5'h10, 2'h0,
			8'h0c, 16'h0);
		ctx(2'h0, 9'h004, 2'h0, 2'h0, 8'h00, 32'h0);
		run(4'h0, 3'h2, 16'h002b, 8'h0b, 32'h0ffe, 32'h0fff, 5'h4, 2'h0,
			8'h0c, 16'h0028);
		ctx(2'h0, 9'h000, 2'h0, 2'h0, 8'h00, 32'h0);
		ld(4'h2, 3'h2, 16'h0043, 8'h0a, 32'h0, 8'h0c, 16'h0040);
		rreg(fault_pkg::REG_STAT, v);
		cmp(v[7:0], lastVec);
		cmp(v[31:16], lastCode);
		wreg(fault_pkg::REG_STAT, 32'h0);
		rreg(fault_pkg::REG_EIP, v);
		cmp(v, lastIp);
		rreg(fault_pkg::REG_CS, v);
		cmp(v[15:0], lastCs);
		rreg(fault_pkg::REG_STAT, v);
		cmp(v[7:0], 8'h0c);
		$display("Test stack faults done");
		ld(4'h2, 3'h2, 16'h0030, 8'h03, 32'h0, 8'h0d, 16'h0030);
		ld(4'h2, 3'h2, 16'h0002, 8'h0b, 32'h0, 8'h0d, 16'h0);
		ld(4'h2, 3'h2, 16'h0030, 8'h0f, 32'h0, 8'h0d, 16'h0030);
		ld(4'h2, 3'h3, 16'h0038, 8'h01, 32'h0, 8'h0d, 16'h0038);
		ld(4'h2, 3'h3, 16'h0038, 8'h07, 32'h0, 8'h0d, 16'h0038);
		ld(4'h2, 3'h1, 16'h0038, 8'h0b, 32'h0, 8'h0d, 16'h0038);
		ld(4'h2, 3'h1, 16'h0000, 8'h0f, 32'h0, 8'h0d, 16'h0);
		ld(4'h2, 3'h3, 16'h0038, 8'h0a, 32'h0, 8'h00, 16'h0);
		run(4'h2, 3'h3, 16'h0048, 8'h0b, 32'h0, 32'h47, 5'h0, 2'h0,
			8'h0d, 16'h0048);
		run(4'h2, 3'h3, 16'h0048, 8'h0b, 32'h0, 32'h4f, 5'h0, 2'h0,
			8'h00, 16'h0);
		ctx(2'h0, 9'h010, 2'h0, 2'h0, 8'h00, 32'h0);
		ld(4'h2, 3'h2, 16'h0030, 8'h03, 32'h0, 8'h0a, 16'h0030);
		$display("Test segment loads done");
		for (i = 0; i < 2; i++) begin
			lag <= i ? 4'h7 : 4'h0;
			ctx(2'h0, 9'h018, 2'h0, 2'h0, 8'h00, 32'h0);
			ld(4'h2, 3'h2, 16'h0040, 8'h0a, 32'h0, 8'h0c, 16'h0040);
		end
		ld(4'h2, 3'h3, 16'h0048, 8'h01, 32'h0, 8'h0d, 16'h0048);
		ctx(2'h0, 9'h000, 2'h0, 2'h0, 8'h00, 32'h0);
		$display("Test task switch commit done");
		run(4'h0, 3'h1, 16'h8, 8'h0f, 32'h10, 32'hff, 5'h4, 2'h2,
			8'h0d, 16'h0);
		run(4'h0, 3'h3, 16'h8, 8'h03, 32'h10, 32'hff, 5'h4, 2'h2,
			8'h0d, 16'h0);
		run(4'h0, 3'h1, 16'h8, 8'h07, 32'h10, 32'hff, 5'h4, 2'h0,
			8'h0d, 16'h0);
		run(4'h0, 3'h3, 16'h3, 8'h0b, 32'h10, 32'hff, 5'h4, 2'h0,
			8'h0d, 16'h0);
		run(4'h0, 3'h2, 16'h8, 8'h0b, 32'h104, 32'hfff, 5'h10, 2'h1,
			8'h0d, 16'h0);
		run(4'h0, 3'h3, 16'h8, 8'h0b, 32'h100, 32'hfff, 5'h10, 2'h1,
			8'h00, 16'h0);
		ld(4'h3, 3'h1, 16'h0050, 8'h0b, 32'h0, 8'h0d, 16'h0050);
		ld(4'h3, 3'h1, 16'h0000, 8'h0f, 32'h0, 8'h0d, 16'h0);
		ld(4'h4, 3'h1, 16'h0000, 8'h0f, 32'h0, 8'h0d, 16'h0);
		ld(4'h4, 3'h1, 16'h0058, 8'h0b, 32'h0, 8'h0d, 16'h0058);
		$display("Test access rights done");
		ld(4'h6, 3'h0, 16'h0060, 8'hb1, 32'h0, 8'h0d, 16'h0060);
		ld(4'h6, 3'h0, 16'h0064, 8'h91, 32'h0, 8'h0d, 16'h0064);
		ld(4'h6, 3'h0, 16'h0060, 8'h91, 32'h0, 8'h00, 16'h0);
		ctx(2'h0, 9'h040, 2'h0, 2'h0, 8'h00, 32'h0);
		ld(4'h6, 3'h0, 16'h0060, 8'h91, 32'h0, 8'h0d, 16'h0060);
		ld(4'h7, 3'h0, 16'h006c, 8'h21, 32'h0, 8'h0d, 16'h006c);
		ld(4'h7, 3'h0, 16'h0068, 8'h91, 32'h0, 8'h0d, 16'h0068);
		ld(4'h8, 3'h0, 16'h0070, 8'hb1, 32'h0, 8'h0d, 16'h0070);
		ld(4'h8, 3'h0, 16'h0074, 8'h91, 32'h0, 8'h0d, 16'h0074);
		$display("Test tables and tasks done");
		ld(4'h9, 3'h0, 16'h0, 8'h00, 32'h80000000, 8'h0d, 16'h0);
		ld(4'h9, 3'h0, 16'h0, 8'h00, 32'h20000000, 8'h0d, 16'h0);
		ld(4'h9, 3'h0, 16'h0, 8'h00, 32'h80000001, 8'h00, 16'h0);
		ld(4'h9, 3'h4, 16'h0, 8'h00, 32'h00000800, 8'h0d, 16'h0);
		ld(4'hb, 3'h0, 16'h0, 8'h00, 32'h00010000, 8'h0d, 16'h0);
		ctx(2'h0, 9'h003, 2'h0, 2'h0, 8'h00, 32'h000000f0);
		ld(4'h9, 3'h3, 16'h0, 8'h00, 32'h00001000, 8'h0d, 16'h0);
		ld(4'ha, 3'h0, 16'h0, 8'h00, 32'h00000010, 8'h0d, 16'h0);
		ld(4'ha, 3'h0, 16'h0, 8'h00, 32'h0000000f, 8'h00, 16'h0);
		ld(4'hd, 3'h0, 16'h0, 8'h00, 32'h0, 8'h00, 16'h0);
		run(4'hd, 3'h0, 16'h0, 8'h00, 32'h0, 32'h0, 5'hf, 2'h0,
			8'h00, 16'h0);
		run(4'hd, 3'h0, 16'h0, 8'h00, 32'h0, 32'h0, 5'h10, 2'h0,
			8'h0d, 16'h0);
		$display("Test control writes done");
		ctx(2'h0, 9'h080, 2'h0, 2'h0, 8'h21, 32'h0);
		ld(4'h5, 3'h0, 16'h0008, 8'h1f, 32'h0, 8'h0d, ic(8'h21, 1'h1));
		ctx(2'h3, 9'h100, 2'h0, 2'h0, 8'h30, 32'h0);
		ld(4'h5, 3'h0, 16'h0008, 8'he1, 32'h0, 8'h0d, ic(8'h30, 1'h0));
		ld(4'hc, 3'h0, 16'h0, 8'h00, 32'h0, 8'h0d, 16'h0);
		ctx(2'h0, 9'h020, 2'h0, 2'h1, 8'h30, 32'h0);
		ld(4'h5, 3'h0, 16'h0018, 8'he1, 32'h0, 8'h0d, 16'h0018);
		ctx(2'h0, 9'h000, 2'h0, 2'h0, 8'h30, 32'h0);
		ld(4'h5, 3'h0, 16'h0018, 8'hf1, 32'h0, 8'h00, 16'h0);
		ld(4'hc, 3'h0, 16'h0, 8'h00, 32'h0, 8'h00, 16'h0);
		$display("Test interrupts and privilege done");
		wreg(fault_pkg::REG_CTRL, 32'h0);
		rreg(fault_pkg::REG_CTRL, v);
		cmp(v, 32'h0);
		ld(4'h2, 3'h2, 16'h0030, 8'h0f, 32'h0, 8'h00, 16'h0);
		wreg(fault_pkg::REG_CTRL, 32'h1);
		ld(4'h2, 3'h2, 16'h0030, 8'h0f, 32'h0, 8'h0d, 16'h0030);
		$display("Test enable done");
		results();
	end

	// The tests need a few hundred cycles; this allows ample margin.
	initial begin
		#200000;
		errors++;
		results();
	end
endmodule // stack_and_protection_fault_detect_bench

`default_nettype wire
